// ### src/psinit_cfg.svh
`ifndef PSINIT_CFG_SVH
`define PSINIT_CFG_SVH
`define PSINIT_A_ID0      4'h0
`define PSINIT_A_CTRL     4'h8
`define PSINIT_A_STAT     4'h9
`define PSINIT_CTRL_RST   16'h0000
`define PSINIT_PH1_MS     100
`define PSINIT_CLK_KHZ    10000
`define PSINIT_STAT_READY 10'h1E7
`define PSINIT_STAT_DEFCT 10'h1F4
`define PSINIT_NIB_LAST   5'h1F
`define PSINIT_NREP_LAST  2'h3
`define PSINIT_NIB_BITS   5'h04
`define PSINIT_STAT_BITS  5'h0A
`define PSINIT_NIB_TYPE_LO 5'h05
`define PSINIT_NIB_TYPE_HI 5'h06
`endif

// ### src/psinit_pkg.sv
package psinit_pkg;
   typedef enum logic [4:0] {
      PSINIT_IDLE   = 5'h01,
      PSINIT_PH1    = 5'h02,
      PSINIT_PH2    = 5'h04,
      PSINIT_PH3    = 5'h08,
      PSINIT_NORMAL = 5'h10
   } psinit_state_type;
   typedef struct packed {
      logic        valid;
      logic        status_error_flag_bit;
      logic [15:0] data;
      logic [4:0]  nbits;
   } psinit_frame_type;
endpackage

// ### src/psinit_seq.sv
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "psinit_cfg.svh"
// Behaviour
// - Reset from power-on or undervoltage starts the initialization sequence.
// - Three successive phases; configuration may skip later ones.
// - Sequence select ends after phase one, two or three.
// - Phase one sends no frames; a frame in flight at an undervoltage restart still shifts out.
// - Phase one ends at self-test done or after 100 ms.
// - Phase two sends fixed-format and optional identification content.
// - Phase two repetition count comes from the setup repeat field.
// - Each identification nibble repeats up to four times.
// - Phase two frames carry status flag zero.
// - First nibble is word seven bits 15 to 12.
// - Nibbles two, three are word seven bits 11:8 and 7:4.
// - Nibble four word seven low, nibble five word six top.
// - Nibbles six to nine from word six then word five top.
// - Nibbles ten to twelve from word five 11:8, 7:4, 3:0.
// - Nibbles thirteen to sixteen from word four, high first.
// - Nibbles seventeen to thirty-two from words three to zero.
// - Phase three flags error on defect, sends 0x1E7 ready or 0x1F4 defect.
// - Phase three repeats two to 256 times, steps of two.
// - Frame data bits leave least significant bit first.
module psinit_seq #(
   parameter int unsigned PH1_CYCLES = `PSINIT_PH1_MS * `PSINIT_CLK_KHZ
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        undervoltage_i,
   input  wire logic        selftest_done_i,
   input  wire logic        sensor_defect_i,
   input  wire logic        frame_done_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   output logic             tx_bit_o,
   output logic             tx_active_o,
   output psinit_pkg::psinit_frame_type frame_o,
   output logic             normal_mode_o
);
   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [15:0] identification_words [0:7];
   logic [15:0] ctrl;
   psinit_pkg::psinit_state_type state;
   logic [31:0] tcnt;
   logic [4:0]  nib;
   logic [1:0]  nrep;
   logic [3:0]  prep;
   logic [7:0]  rep3;
   logic [4:0]  bitc;
   logic        busy;
   logic [15:0] shreg;
   logic        seq_rst;

   // Control fields: [1:0] sequence, [2] phase-one duration select,
   // [6:3] phase-two repeat, [8:7] nibble repeat, [15:9] phase-three
   // repeat pairs minus one.
   wire [1:0] seq_sel   = ctrl[1:0];
   wire       first_phase_duration_select = ctrl[2];
   wire [3:0] ph2_rep   = ctrl[6:3];
   wire [1:0] nib_rep   = ctrl[8:7];
   wire [7:0] third_phase_repeat_count = {ctrl[15:9], 1'b1};

   wire wr_id   = wr_i && (addr_i < `PSINIT_A_CTRL);
   wire wr_ctrl = wr_i && (addr_i == `PSINIT_A_CTRL);

   // ------------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_id
         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               identification_words[gi] <= 16'h0000;
            end else if (wr_id && addr_i[2:0] == gi[2:0]) begin
               identification_words[gi] <= wdata_i;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl <= `PSINIT_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl <= wdata_i;
      end
   end

   wire [15:0] stat_word = {11'h000, state};
   wire [15:0] next_rdata =
      (addr_i < `PSINIT_A_CTRL) ? identification_words[addr_i[2:0]] :
      (addr_i == `PSINIT_A_CTRL) ? ctrl :
      (addr_i == `PSINIT_A_STAT) ? stat_word : 16'h0000;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= rd_i ? next_rdata : 16'h0000;
      end
   end

   // ------------------------------------------------------------------
   // Nibble selection
   // ------------------------------------------------------------------
   // Nibble k (0-based) comes from word 7 - k/4, high nibble first, except
   // that the sensor type pair takes the middle of word 6 low nibble first.
   wire [2:0]  wsel   = 3'h7 - nib[4:2];
   wire [15:0] wsrc   = identification_words[wsel];
   wire        type_pair = (nib == `PSINIT_NIB_TYPE_LO) ||
                           (nib == `PSINIT_NIB_TYPE_HI);
   wire [1:0]  npos   = type_pair ? nib[1:0]
                                  : 2'h3 - nib[1:0];
   wire [3:0]  nibval = wsrc[{npos, 2'b00} +: 4];

   wire nib_last  = (nib == `PSINIT_NIB_LAST) && (nrep == nib_rep);
   wire ph2_last  = nib_last && (prep == ph2_rep);
   wire ph3_last  = (rep3 == third_phase_repeat_count);
   wire ph1_done  = first_phase_duration_select ?
                    (tcnt >= PH1_CYCLES - 1) : selftest_done_i;
   wire send      = (state == psinit_pkg::PSINIT_PH2 ||
                     state == psinit_pkg::PSINIT_PH3) && !busy && !seq_rst;

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         seq_rst <= 1'b1;
      end else begin
         seq_rst <= undervoltage_i;
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= psinit_pkg::PSINIT_IDLE;
         tcnt  <= 32'h0000_0000;
         nib   <= 5'h00;
         nrep  <= 2'h0;
         prep  <= 4'h0;
         rep3  <= 8'h00;
      end else if (seq_rst) begin
         state <= psinit_pkg::PSINIT_PH1;
         tcnt  <= 32'h0000_0000;
         nib   <= 5'h00;
         nrep  <= 2'h0;
         prep  <= 4'h0;
         rep3  <= 8'h00;
      end else begin
         case (state)
            psinit_pkg::PSINIT_PH1: begin
               tcnt <= tcnt + 32'h0000_0001;
               if (ph1_done) begin
                  if (seq_sel == 2'h0) begin
                     state <= psinit_pkg::PSINIT_NORMAL;
                  end else begin
                     state <= psinit_pkg::PSINIT_PH2;
                  end
               end
            end
            psinit_pkg::PSINIT_PH2: begin
               if (send) begin
                  if (nrep != nib_rep) begin
                     nrep <= nrep + 2'h1;
                  end else begin
                     nrep <= 2'h0;
                     nib  <= nib + 5'h01;
                     if (nib == `PSINIT_NIB_LAST) begin
                        prep <= prep + 4'h1;
                     end
                  end
                  if (ph2_last) begin
                     state <= (seq_sel == 2'h1) ?
                              psinit_pkg::PSINIT_NORMAL :
                              psinit_pkg::PSINIT_PH3;
                  end
               end
            end
            psinit_pkg::PSINIT_PH3: begin
               if (send) begin
                  rep3 <= rep3 + 8'h01;
                  if (ph3_last) begin
                     state <= psinit_pkg::PSINIT_NORMAL;
                  end
               end
            end
            psinit_pkg::PSINIT_NORMAL: begin
               state <= psinit_pkg::PSINIT_NORMAL;
            end
            default: begin
               state <= psinit_pkg::PSINIT_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Frame output and serializer
   // ------------------------------------------------------------------
   wire is_ph2 = (state == psinit_pkg::PSINIT_PH2);
   wire [15:0] ph3_word = {6'h00, sensor_defect_i ? `PSINIT_STAT_DEFCT
                                                  : `PSINIT_STAT_READY};
   wire [15:0] next_data = is_ph2 ? {12'h000, nibval} : ph3_word;
   wire [4:0]  next_nbits = is_ph2 ? `PSINIT_NIB_BITS : `PSINIT_STAT_BITS;
   wire        next_flag = is_ph2 ? 1'b0 : sensor_defect_i;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_o <= '0;
         busy    <= 1'b0;
         shreg   <= 16'h0000;
         bitc    <= 5'h00;
      end else if (send) begin
         frame_o <= '{1'b1, next_flag, next_data, next_nbits};
         shreg   <= next_data;
         bitc    <= next_nbits;
         busy    <= 1'b1;
      end else begin
         frame_o.valid <= 1'b0;
         if (busy && bitc != 5'h00) begin
            shreg <= {1'b0, shreg[15:1]};
            bitc  <= bitc - 5'h01;
         end else if (busy && frame_done_i) begin
            busy <= 1'b0;
         end
      end
   end

   assign tx_bit_o      = busy && bitc != 5'h00 && shreg[0];
   assign tx_active_o   = busy && bitc != 5'h00;
   assign normal_mode_o = (state == psinit_pkg::PSINIT_NORMAL);

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   wire in_ph1 = (state == psinit_pkg::PSINIT_PH1);
   wire in_ph3 = (state == psinit_pkg::PSINIT_PH3);

   default clocking chk_cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   ph1_silent_a: assert property (
      in_ph1 |-> !frame_o.valid && !send)
      else $error("Frame started in phase one.");

   ph1_line_a: assert property (
      in_ph1 && !busy |-> !tx_active_o && !tx_bit_o)
      else $error("Output not idle in phase one.");

   ph1_stay_a: assert property (
      in_ph1 && !ph1_done && !seq_rst |=> in_ph1)
      else $error("Phase one left too early.");

   ph2_entry_a: assert property (
      in_ph1 && ph1_done && seq_sel != 2'h0 && !seq_rst |=> is_ph2)
      else $error("Phase two not entered.");

   skip_ph2_a: assert property (
      in_ph1 && ph1_done && seq_sel == 2'h0 && !seq_rst |=> normal_mode_o)
      else $error("Sequence select ignored after phase one.");

   ph2_exit_a: assert property (
      is_ph2 && send && ph2_last && seq_sel == 2'h1 |=> normal_mode_o)
      else $error("Sequence select ignored after phase two.");

   ph3_entry_a: assert property (
      is_ph2 && send && ph2_last && seq_sel[1] |=> in_ph3)
      else $error("Phase three not entered.");

   ph3_exit_a: assert property (
      in_ph3 && send && ph3_last |=> normal_mode_o)
      else $error("Phase three did not end.");

   ph3_repeat_a: assert property (
      in_ph3 && send && !ph3_last |=> in_ph3)
      else $error("Phase three ended early.");

   nib_repeat_a: assert property (
      is_ph2 && send && nrep != nib_rep |=> nib == $past(nib))
      else $error("Nibble advanced before its repeats.");

   nib_step_a: assert property (
      is_ph2 && send && nrep == nib_rep |=> nib == $past(nib) + 5'h01)
      else $error("Nibble did not advance.");

   ph2_flag_a: assert property (
      send && is_ph2 |=> frame_o.valid && !frame_o.status_error_flag_bit)
      else $error("Phase two frame flag not zero.");

   ph2_width_a: assert property (
      send && is_ph2 |=>
      frame_o.nbits == `PSINIT_NIB_BITS && frame_o.data[15:4] == 12'h000)
      else $error("Phase two frame is not one nibble.");

   ph3_code_a: assert property (
      send && in_ph3 |=> frame_o.data[9:0] == $past(ph3_word[9:0]))
      else $error("Wrong phase three status code.");

   ph3_width_a: assert property (
      send && in_ph3 |=>
      frame_o.nbits == `PSINIT_STAT_BITS && frame_o.data[15:10] == 6'h00)
      else $error("Phase three frame is not ten bits.");

   ph3_flag_a: assert property (
      send && in_ph3 |=>
      frame_o.status_error_flag_bit == $past(sensor_defect_i))
      else $error("Phase three flag does not show the defect.");

   first_nib_a: assert property (
      send && is_ph2 && nib == 5'h00 |=>
      frame_o.data[3:0] == $past(identification_words[7][15:12]))
      else $error("First nibble not revision field.");

   count_nib_a: assert property (
      send && is_ph2 && nib == 5'h01 |=>
      frame_o.data[3:0] == $past(identification_words[7][11:8]))
      else $error("Second nibble not count field.");

   maker_low_a: assert property (
      send && is_ph2 && nib == 5'h03 |=>
      frame_o.data[3:0] == $past(identification_words[7][3:0]))
      else $error("Fourth nibble not maker low field.");

   type_low_a: assert property (
      send && is_ph2 && nib == `PSINIT_NIB_TYPE_LO |=>
      frame_o.data[3:0] == $past(identification_words[6][7:4]))
      else $error("Sixth nibble not sensor type low field.");

   type_high_a: assert property (
      send && is_ph2 && nib == `PSINIT_NIB_TYPE_HI |=>
      frame_o.data[3:0] == $past(identification_words[6][11:8]))
      else $error("Seventh nibble not sensor type high field.");

   sensor_code_a: assert property (
      send && is_ph2 && nib == 5'h09 |=>
      frame_o.data[3:0] == $past(identification_words[5][11:8]))
      else $error("Tenth nibble not sensor code field.");

   date_first_a: assert property (
      send && is_ph2 && nib == 5'h0C |=>
      frame_o.data[3:0] == $past(identification_words[4][15:12]))
      else $error("Thirteenth nibble not date high field.");

   serial_last_a: assert property (
      send && is_ph2 && nib == `PSINIT_NIB_LAST |=>
      frame_o.data[3:0] == $past(identification_words[0][3:0]))
      else $error("Last nibble not lowest serial field.");

   normal_stay_a: assert property (
      normal_mode_o && !seq_rst |=> normal_mode_o)
      else $error("Left normal mode without reset.");

   seq_start_a: assert property (
      seq_rst |=> in_ph1)
      else $error("Reset did not start phase one.");

   lsb_first_a: assert property (
      send |=> tx_bit_o == frame_o.data[0])
      else $error("First bit is not the LSB.");

   shift_order_a: assert property (
      tx_active_o && bitc > 5'h01 |=> tx_bit_o == $past(shreg[1]))
      else $error("Bits not shifted in order.");

   valid_pulse_a: assert property (
      frame_o.valid |=> !frame_o.valid)
      else $error("Frame valid longer than one cycle.");

   frame_hold_a: assert property (
      busy && bitc == 5'h00 && !frame_done_i |=> busy)
      else $error("Serializer released without frame done.");
endmodule

// ### tb/psinit_ecu_rx.sv
`timescale 1ns/10ps
// ------------------------------
// Receiver model
// ------------------------------
module psinit_ecu_rx (
   input  wire logic        mclk_i,
   input  wire logic        tx_bit_i,
   input  wire logic        start_i,
   input  wire logic [4:0]  nbits_i,
   input  wire logic [3:0]  delay_i,
   output logic             done_o,
   output logic      [15:0] word_o
);
   int cnt = 99;
   int wait_c = 0;
   initial begin
      done_o = 1'b0;
      word_o = 16'h0000;
   end
   // Collects bits in order, LSB first, then releases the sender.
   always @(posedge mclk_i) begin
      done_o <= 1'b0;
      if (start_i) begin
         word_o <= {15'h0000, tx_bit_i};
         cnt <= 1;
         wait_c <= 0;
      end else if (cnt < nbits_i) begin
         word_o[cnt] <= tx_bit_i;
         cnt <= cnt + 1;
      end else if (cnt == nbits_i && wait_c >= delay_i) begin
         done_o <= 1'b1;
         cnt <= 99;
      end else if (cnt == nbits_i) begin
         wait_c <= wait_c + 1;
      end
   end
endmodule

// ### tb/tb_psinit_seq.sv
`timescale 1ns/10ps
module tb_psinit_seq;
   logic mclk_i = 1'b0, rst_i = 1'b1, uv = 1'b0, st = 1'b0, dfct = 1'b0;
   logic wr = 1'b0, rd = 1'b0, done, tx_bit, tx_act, norm;
   logic [3:0] addr = 4'h0, dly = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata, rxw, last;
   psinit_pkg::psinit_frame_type frame;
   int num_errors = 0;
   int checks = 0;
   logic [15:0] id [8] = '{16'h0123, 16'h4567, 16'h89AB, 16'hCDEF,
                           16'hF0E1, 16'hD2C3, 16'hB4A5, 16'h9687};
   initial forever #50 mclk_i = ~mclk_i;
   psinit_seq #(.PH1_CYCLES(20)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
      .undervoltage_i(uv), .selftest_done_i(st), .sensor_defect_i(dfct),
      .frame_done_i(done), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .tx_bit_o(tx_bit), .tx_active_o(tx_act),
      .frame_o(frame), .normal_mode_o(norm));
   psinit_ecu_rx ecu (.mclk_i(mclk_i), .tx_bit_i(tx_bit),
      .start_i(frame.valid), .nbits_i(frame.nbits), .delay_i(dly),
      .done_o(done), .word_o(rxw));
   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr_reg(logic [3:0] a, logic [15:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(logic [3:0] a, logic [15:0] exp);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1 check("rdata", rdata, exp);
   endtask
   function automatic logic [3:0] nib(int k);
      int s;
      s = (k == 5) ? 1 : (k == 6) ? 2 : 3 - k % 4;
      return id[7 - k / 4][4 * s +: 4];
   endfunction
   // Restarts by undervoltage, configures, counts and judges every frame.
   task automatic run(logic [15:0] ctrl, logic d, logic [3:0] dl,
                      int n2, int nrep, int n3);
      int nf;
      int i;
      logic [15:0] msk;
      logic [15:0] ph3_exp;
      logic [3:0]  exp_n;
      logic        flg;
      nf = 0;
      ph3_exp = d ? 16'h01F4 : 16'h01E7;
      @(posedge mclk_i);
      st <= 1'b0;
      uv <= 1'b1;
      @(posedge mclk_i);
      uv <= 1'b0;
      for (i = 0; i < 8; i++) wr_reg(4'(i), id[i]);
      wr_reg(4'h8, ctrl);
      dfct <= d;
      dly <= dl;
      st <= 1'b1;
      for (i = 0; i < 6000 && norm !== 1'b1; i++) begin
         @(posedge mclk_i);
         #1;
         if (done === 1'b1) begin
            msk = 16'((17'h1 << frame.nbits) - 1);
            check("lsb first", rxw, last & msk);
         end
         if (frame.valid === 1'b1) begin
            last = frame.data;
            flg = frame.status_error_flag_bit;
            check("tx active", 16'(tx_act), 16'h0001);
            if (nf < n2) begin
               exp_n = nib((nf / nrep) % 32);
               check("nibble", 16'(frame.data[3:0]), 16'(exp_n));
               check("ph2 flag", 16'(flg), 16'h0000);
            end else begin
               check("ph3 code", 16'(frame.data[9:0]), ph3_exp);
               check("ph3 flag", 16'(flg), 16'(d));
            end
            nf++;
         end
      end
      if (norm !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
      check("frames", 16'(nf), 16'(n2 + n3));
      rd_reg(4'h9, 16'h0010);
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs();
      rd_reg(4'h8, 16'h0000);
      wr_reg(4'h3, 16'hA5C3);
      rd_reg(4'h3, 16'hA5C3);
      wr_reg(4'hA, 16'hFFFF);
      rd_reg(4'hA, 16'h0000);
      rd_reg(4'hF, 16'h0000);
   endtask
   task automatic t_ph1_timer();
      int i;
      logic [3:0] q;
      @(posedge mclk_i);
      uv <= 1'b1;
      @(posedge mclk_i);
      uv <= 1'b0;
      wr_reg(4'h8, 16'h0004);
      st <= 1'b1;
      for (i = 0; i < 14; i++) begin
         @(posedge mclk_i);
         #1 q = {tx_act, tx_bit, norm, frame.valid};
         check("ph1 quiet", 16'(q), 16'h0000);
      end
      for (i = 0; i < 40 && norm !== 1'b1; i++) @(posedge mclk_i);
      #1 check("ph1 timer end", 16'(norm), 16'h0001);
   endtask
   task automatic t_ph1_only();
      run(16'h0000, 1'b0, 4'h0, 0, 1, 0);
   endtask
   task automatic t_ph2_reps();
      run(16'h0189, 1'b0, 4'h0, 256, 4, 0);
   endtask
   task automatic t_ph3_defect();
      run(16'h0202, 1'b1, 4'h3, 32, 1, 4);
   endtask
   task automatic t_ph3_ready();
      run(16'h0002, 1'b0, 4'h1, 32, 1, 2);
   endtask
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_regs();
      t_ph1_timer();
      t_ph1_only();
      t_ph2_reps();
      t_ph3_defect();
      t_ph3_ready();
      tally_and_finish();
   end
endmodule
